/* rtl/idmar_regs.sv */
// module: channel 2/3 address and count, status, command, request, mask and mode registers
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - count byte picked by byte pointer
// - address byte picked by byte pointer
// - any write to clear location zeroes pointer
// - status 7:4 show pending requests
// - status 3:0 show terminal count
// - io status read clears flags, mirrored
// - command 7:6 set ack, request polarity
// - command 5:0 timing, priority, enable, copy
// - request write sets or clears soft request
// - single mask write sets or clears mask
// - mode 7:4 mode, direction, auto init
// - mode 3:2 transfer type, 11 illegal
// - type ignored for cascade or copy
// - mode 1:0 select target channel
// - status read, command write share address
module idmar_regs (
   // clock and reset
   input  wire logic                    mclk_i,
   input  wire logic                    resetn_i,
   // io window
   input  wire idmar_pkg::idmar_io_req_t io_req_i,
   output var  idmar_pkg::idmar_io_rsp_t io_rsp_o,
   // bus hold acknowledge, writes ignored while high
   input  wire logic                    hold_acknowledge_i,
   // engine events
   input  wire logic [3:0]              peripheral_request_in_i,
   input  wire logic [3:0]              terminal_count_i,
   // settings to the engine
   output var  idmar_pkg::idmar_cmd_t   cmd_o,
   output logic [3:0]                   chan_mask_o,
   output logic [3:0]                   soft_request_o,
   output var  idmar_pkg::idmar_mode_t [3:0] chan_mode_o,
   output logic [3:0]                   type_valid_o,
   output logic [15:0]                  chan2_address_o,
   output logic [15:0]                  chan2_count_o,
   output logic [15:0]                  chan3_address_o,
   output logic [15:0]                  chan3_count_o,
   // bus status mirror
   output logic [7:0]                   bus_status_o,
   // two-entry read buffer, drain side
   output logic                         rbuf_valid_o,
   output logic [7:0]                   rbuf_data_o,
   input  wire logic                    rbuf_ready_i
);
   import idmar_pkg::*;

   logic        ptr_reg, ptr_next;
   idmar_cmd_t  cmd_reg, cmd_next;
   logic [3:0]  mask_reg, mask_next, sreq_reg, sreq_next;
   logic [3:0]  rq_reg, rq_next, tc_reg, tc_next;
   idmar_mode_t [3:0] mode_reg, mode_next;
   logic [3:0]  tvld_reg, tvld_next;
   logic [15:0] a2_reg, a2_next, c2_reg, c2_next, a3_reg, a3_next, c3_reg, c3_next;
   idmar_io_rsp_t rsp_reg, rsp_next;
   logic [7:0]  buf_reg [2];
   logic [7:0]  buf_next [2];
   logic [1:0]  cnt_reg, cnt_next;
   logic        bvld_reg, bvld_next;
   logic        wr_ok, word_acc, rd_take, push, pop;
   logic [7:0]  rd_val, status_val;

   assign wr_ok = io_req_i.wr && !hold_acknowledge_i;
   assign status_val = {rq_reg, tc_reg};
   assign word_acc = (io_req_i.addr >= OFS_CH2_ADDR) && (io_req_i.addr <= OFS_CH3_COUNT);
   // a read is taken only while the buffer has room
   assign rd_take = io_req_i.rd && (cnt_reg != 2'd2);
   assign push = rd_take;
   assign pop = (cnt_reg != 2'd0) && rbuf_ready_i;

   // read data select
   always_comb begin
      rd_val = 8'h00;
      if (io_req_i.addr == OFS_CH2_ADDR) begin
         rd_val = ptr_reg ? a2_reg[15:8] : a2_reg[7:0];
      end else if (io_req_i.addr == OFS_CH2_COUNT) begin
         rd_val = ptr_reg ? c2_reg[15:8] : c2_reg[7:0];
      end else if (io_req_i.addr == OFS_CHAN3_CURRENT_ADDRESS) begin
         rd_val = ptr_reg ? a3_reg[15:8] : a3_reg[7:0];
      end else if (io_req_i.addr == OFS_CH3_COUNT) begin
         rd_val = ptr_reg ? c3_reg[15:8] : c3_reg[7:0];
      end else if (io_req_i.addr == OFS_STAT_CMD) begin
         rd_val = status_val;
      end
   end

   // next values of the register file
   always_comb begin
      ptr_next  = ptr_reg;
      cmd_next  = cmd_reg;
      mask_next = mask_reg;
      sreq_next = sreq_reg;
      mode_next = mode_reg;
      tvld_next = tvld_reg;
      a2_next   = a2_reg;
      c2_next   = c2_reg;
      a3_next   = a3_reg;
      c3_next   = c3_reg;
      // status flags: a read clears, a new event in the same cycle wins
      rq_next = rq_reg;
      tc_next = tc_reg;
      if (rd_take && io_req_i.addr == OFS_STAT_CMD) begin
         rq_next = 4'h0;
         tc_next = 4'h0;
      end
      rq_next = rq_next | peripheral_request_in_i | sreq_reg;
      tc_next = tc_next | terminal_count_i;
      // byte pointer advances on each word byte access
      if ((wr_ok || rd_take) && word_acc) begin
         ptr_next = !ptr_reg;
      end
      if (wr_ok) begin
         if (io_req_i.addr == OFS_CH2_ADDR) begin
            if (ptr_reg) a2_next[15:8] = io_req_i.wdata;
            else a2_next[7:0] = io_req_i.wdata;
         end else if (io_req_i.addr == OFS_CH2_COUNT) begin
            if (ptr_reg) c2_next[15:8] = io_req_i.wdata;
            else c2_next[7:0] = io_req_i.wdata;
         end else if (io_req_i.addr == OFS_CHAN3_CURRENT_ADDRESS) begin
            if (ptr_reg) a3_next[15:8] = io_req_i.wdata;
            else a3_next[7:0] = io_req_i.wdata;
         end else if (io_req_i.addr == OFS_CH3_COUNT) begin
            if (ptr_reg) c3_next[15:8] = io_req_i.wdata;
            else c3_next[7:0] = io_req_i.wdata;
         end else if (io_req_i.addr == OFS_STAT_CMD) begin
            cmd_next = idmar_cmd_t'(io_req_i.wdata);
         end else if (io_req_i.addr == OFS_SW_REQ) begin
            sreq_next[io_req_i.wdata[1:0]] = io_req_i.wdata[SETCLR_BIT];
         end else if (io_req_i.addr == OFS_SNGL_MASK) begin
            mask_next[io_req_i.wdata[1:0]] = io_req_i.wdata[SETCLR_BIT];
         end else if (io_req_i.addr == OFS_MODE) begin
            mode_next[io_req_i.wdata[1:0]] = idmar_mode_t'(io_req_i.wdata);
         end else if (io_req_i.addr == OFS_PTR_CLEAR) begin
            ptr_next = 1'b0;
         end
      end
      // transfer type counts only outside cascade and memory copy
      for (int i = 0; i < NUM_CH; i++) begin
         tvld_next[i] = (mode_next[i].xmode != IDMAR_CASCADE) &&
                        !cmd_next.memory_copy_enable &&
                        (mode_next[i].transfer_type_field != IDMAR_ILLEGAL);
      end
   end

   // read answer and two-entry buffer next state
   always_comb begin
      rsp_next.valid = rd_take;
      rsp_next.rdata = rd_take ? rd_val : rsp_reg.rdata;
      buf_next[0] = buf_reg[0];
      buf_next[1] = buf_reg[1];
      cnt_next = cnt_reg;
      if (pop) begin
         buf_next[0] = buf_reg[1];
      end
      if (push) begin
         buf_next[(pop ? cnt_reg - 2'd1 : cnt_reg) == 2'd0 ? 0 : 1] = rd_val;
      end
      cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
      bvld_next = (cnt_next != 2'd0); // head valid kept in its own flop
   end

   // registers
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ptr_reg  <= 1'b0;
         cmd_reg  <= idmar_cmd_t'(CMD_RESET);
         mask_reg <= MASK_RESET;
         sreq_reg <= 4'h0;
         rq_reg   <= 4'h0;
         tc_reg   <= 4'h0;
         mode_reg <= '{default: idmar_mode_t'(MODE_RESET)};
         tvld_reg <= 4'h0;
         a2_reg   <= WORD_RESET;
         c2_reg   <= WORD_RESET;
         a3_reg   <= WORD_RESET;
         c3_reg   <= WORD_RESET;
         rsp_reg  <= '0;
         buf_reg[0] <= 8'h00;
         buf_reg[1] <= 8'h00;
         cnt_reg  <= 2'd0;
         bvld_reg <= 1'b0;
      end else begin
         ptr_reg  <= ptr_next;
         cmd_reg  <= cmd_next;
         mask_reg <= mask_next;
         sreq_reg <= sreq_next;
         rq_reg   <= rq_next;
         tc_reg   <= tc_next;
         mode_reg <= mode_next;
         tvld_reg <= tvld_next;
         a2_reg   <= a2_next;
         c2_reg   <= c2_next;
         a3_reg   <= a3_next;
         c3_reg   <= c3_next;
         rsp_reg  <= rsp_next;
         buf_reg[0] <= buf_next[0];
         buf_reg[1] <= buf_next[1];
         cnt_reg  <= cnt_next;
         bvld_reg <= bvld_next;
      end
   end

   // outputs straight from flip-flops
   assign io_rsp_o        = rsp_reg;
   assign cmd_o           = cmd_reg;
   assign chan_mask_o     = mask_reg;
   assign soft_request_o  = sreq_reg;
   assign chan_mode_o     = mode_reg;
   assign type_valid_o    = tvld_reg;
   assign chan2_address_o = a2_reg;
   assign chan2_count_o   = c2_reg;
   assign chan3_address_o = a3_reg;
   assign chan3_count_o   = c3_reg;
   assign bus_status_o    = {rq_reg, tc_reg};
   assign rbuf_valid_o    = bvld_reg;
   assign rbuf_data_o     = buf_reg[0];

   // checks
   property p_ptr_clear;
      @(posedge mclk_i) disable iff (!resetn_i)
      (wr_ok && io_req_i.addr == OFS_PTR_CLEAR) |=> !ptr_reg;
   endproperty
   a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared");

   property p_ptr_toggle;
      @(posedge mclk_i) disable iff (!resetn_i)
      ((wr_ok || rd_take) && word_acc) |=> (ptr_reg != $past(ptr_reg));
   endproperty
   a_ptr_toggle: assert property (p_ptr_toggle) else $error("pointer did not toggle");

   property p_cnt_low;
      @(posedge mclk_i) disable iff (!resetn_i)
      (wr_ok && io_req_i.addr == OFS_CH2_COUNT && !ptr_reg) |=>
      (c2_reg[7:0] == $past(io_req_i.wdata));
   endproperty
   a_cnt_low: assert property (p_cnt_low) else $error("count low byte wrong");

   property p_addr_high;
      @(posedge mclk_i) disable iff (!resetn_i)
      (wr_ok && io_req_i.addr == OFS_CHAN3_CURRENT_ADDRESS && ptr_reg) |=>
      (a3_reg[15:8] == $past(io_req_i.wdata));
   endproperty
   a_addr_high: assert property (p_addr_high) else $error("address high byte wrong");

   property p_tc_set;
      @(posedge mclk_i) disable iff (!resetn_i)
      terminal_count_i[2] |=> bus_status_o[2];
   endproperty
   a_tc_set: assert property (p_tc_set) else $error("terminal flag lost");

   property p_stat_clear;
      @(posedge mclk_i) disable iff (!resetn_i)
      (rd_take && io_req_i.addr == OFS_STAT_CMD && peripheral_request_in_i == 4'h0 &&
       sreq_reg == 4'h0 && terminal_count_i == 4'h0) |=> (bus_status_o == 8'h00);
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");

   property p_stat_read;
      @(posedge mclk_i) disable iff (!resetn_i)
      (rd_take && io_req_i.addr == OFS_STAT_CMD) |=>
      (io_rsp_o.valid && io_rsp_o.rdata == $past(status_val));
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("status read wrong");

   property p_mask;
      @(posedge mclk_i) disable iff (!resetn_i)
      (wr_ok && io_req_i.addr == OFS_SNGL_MASK) |=>
      (chan_mask_o[$past(io_req_i.wdata[1:0])] == $past(io_req_i.wdata[SETCLR_BIT]));
   endproperty
   a_mask: assert property (p_mask) else $error("mask bit wrong");

   property p_sreq;
      @(posedge mclk_i) disable iff (!resetn_i)
      (wr_ok && io_req_i.addr == OFS_SW_REQ && io_req_i.wdata[SETCLR_BIT]) |=>
      soft_request_o[$past(io_req_i.wdata[1:0])] ##1 bus_status_o[4 + $past(io_req_i.wdata[1:0], 2)];
   endproperty
   a_sreq: assert property (p_sreq) else $error("soft request wrong");

   property p_cascade;
      @(posedge mclk_i) disable iff (!resetn_i)
      (chan_mode_o[0].xmode == IDMAR_CASCADE || cmd_o.memory_copy_enable) |-> !type_valid_o[0];
   endproperty
   a_cascade: assert property (p_cascade) else $error("type not ignored");

   property p_hold;
      @(posedge mclk_i) disable iff (!resetn_i)
      (io_req_i.wr && hold_acknowledge_i && io_req_i.addr == OFS_STAT_CMD) |=> $stable(cmd_o);
   endproperty
   a_hold: assert property (p_hold) else $error("write taken during hold");

   c_mode: cover property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_ok && io_req_i.addr == OFS_MODE);
   c_full: cover property (@(posedge mclk_i) disable iff (!resetn_i) cnt_reg == 2'd2);
   c_refused: cover property (@(posedge mclk_i) disable iff (!resetn_i)
      io_req_i.rd && cnt_reg == 2'd2);
   c_stat_rd: cover property (@(posedge mclk_i) disable iff (!resetn_i)
      rd_take && io_req_i.addr == OFS_STAT_CMD && status_val != 8'h00);
   c_word: cover property (@(posedge mclk_i) disable iff (!resetn_i)
      (wr_ok && io_req_i.addr == OFS_CH2_COUNT) ##1 (wr_ok && io_req_i.addr == OFS_CH2_COUNT));
endmodule
`default_nettype wire

/* rtl/idmar_pkg.sv */
// package: register map, field positions and carrier types for the dma channel registers
package idmar_pkg;
   // register offsets within the io window
   localparam logic [3:0] OFS_CH2_ADDR   = 4'h4;
   localparam logic [3:0] OFS_CH2_COUNT  = 4'h5;
   localparam logic [3:0] OFS_CHAN3_CURRENT_ADDRESS   = 4'h6;
   localparam logic [3:0] OFS_CH3_COUNT  = 4'h7;
   localparam logic [3:0] OFS_STAT_CMD   = 4'h8;
   localparam logic [3:0] OFS_SW_REQ     = 4'h9;
   localparam logic [3:0] OFS_SNGL_MASK  = 4'ha;
   localparam logic [3:0] OFS_MODE       = 4'hb;
   localparam logic [3:0] OFS_PTR_CLEAR  = 4'hc;
   // field positions
   localparam int unsigned SETCLR_BIT    = 2;
   localparam int unsigned MEMCOPY_BIT   = 0;
   // reset values
   localparam logic [7:0]  CMD_RESET     = 8'h00;
   localparam logic [3:0]  MASK_RESET    = 4'hf;
   localparam logic [7:0]  MODE_RESET    = 8'h00;
   localparam logic [15:0] WORD_RESET    = 16'h0000;
   // number of channels held here
   localparam int unsigned NUM_CH        = 4;

   // transfer modes and types
   typedef enum logic [1:0] {
      IDMAR_DEMAND  = 2'b00,
      IDMAR_SINGLE  = 2'b01,
      IDMAR_BLOCK   = 2'b10,
      IDMAR_CASCADE = 2'b11
   } idmar_xmode_t;

   typedef enum logic [1:0] {
      IDMAR_VERIFY  = 2'b00,
      IDMAR_WRITE   = 2'b01,
      IDMAR_READ    = 2'b10,
      IDMAR_ILLEGAL = 2'b11
   } idmar_xtype_t;

   // io access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } idmar_io_req_t;

   // io read answer
   typedef struct packed {
      logic       valid;
      logic [7:0] rdata;
   } idmar_io_rsp_t;

   // controller command byte
   typedef struct packed {
      logic ack_low;
      logic req_low;
      logic write_ext;
      logic rotating;
      logic compressed;
      logic disabled;
      logic addr_hold;
      logic memory_copy_enable;
   } idmar_cmd_t;

   // per-channel mode
   typedef struct packed {
      idmar_xmode_t xmode;
      logic         address_direction;
      logic         auto_init;
      idmar_xtype_t transfer_type_field;
      logic [1:0]   chan;
   } idmar_mode_t;
endpackage

/* testbench/idmar_periph.sv */
// peripheral events and read-buffer drain model on the far side
`timescale 1ns/1ps
`default_nettype none
module idmar_periph (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       resetn_i,
   // commands from the bench
   input  wire logic [3:0] rq_ev_i,
   input  wire logic [3:0] tc_ev_i,
   input  wire logic       stall_i,
   // toward the registers
   output logic [3:0]      rq_o,
   output logic [3:0]      tc_o,
   output logic            ready_o,
   input  wire logic       valid_i,
   input  wire logic [7:0] data_i,
   // last drained byte and drain count
   output logic [7:0]      pop_data_o,
   output logic [3:0]      pop_cnt_o
);
   // the drain side stalls on command
   assign ready_o = !stall_i;
   // one-cycle events, and the last drained byte with a drain count
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rq_o       <= 4'h0;
         tc_o       <= 4'h0;
         pop_data_o <= 8'h00;
         pop_cnt_o  <= 4'h0;
      end else begin
         rq_o <= rq_ev_i;
         tc_o <= tc_ev_i;
         if (valid_i && ready_o) begin
            pop_data_o <= data_i;
            pop_cnt_o  <= pop_cnt_o + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the dma channel registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import idmar_pkg::*;
   logic              mclk_i = 1'b0;
   logic              resetn_i = 1'b0;
   logic              hold = 1'b0;
   logic              stall = 1'b0;
   logic [3:0]        rq_ev = 4'h0;
   logic [3:0]        tc_ev = 4'h0;
   logic [3:0]        rq, tc, mask, sreq, tvld, pcnt;
   logic              rdy, bvld;
   logic [7:0]        bdat, bstat, pdat;
   logic [15:0]       a2, c2, a3, c3;
   idmar_io_req_t     req = '0;
   idmar_io_rsp_t     rsp;
   idmar_cmd_t        cmd;
   idmar_mode_t [3:0] mode;
   int                fails = 0;
   int                tests_run = 0;
   int                cyc = 0;
   logic [7:0]        mb [4] = '{8'h04, 8'h69, 8'hda, 8'h8f};
   logic [7:0]        cv [3] = '{8'ha5, 8'h5a, 8'h00};

   // 50 MHz clock
   always #10 mclk_i = ~mclk_i;

   idmar_regs i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .io_req_i(req), .io_rsp_o(rsp),
      .hold_acknowledge_i(hold), .peripheral_request_in_i(rq), .terminal_count_i(tc),
      .cmd_o(cmd), .chan_mask_o(mask), .soft_request_o(sreq), .chan_mode_o(mode),
      .type_valid_o(tvld), .chan2_address_o(a2), .chan2_count_o(c2), .chan3_address_o(a3),
      .chan3_count_o(c3), .bus_status_o(bstat), .rbuf_valid_o(bvld), .rbuf_data_o(bdat),
      .rbuf_ready_i(rdy));

   idmar_periph i_periph (.mclk_i(mclk_i), .resetn_i(resetn_i), .rq_ev_i(rq_ev),
      .tc_ev_i(tc_ev), .stall_i(stall), .rq_o(rq), .tc_o(tc), .ready_o(rdy), .valid_i(bvld),
      .data_i(bdat), .pop_data_o(pdat), .pop_cnt_o(pcnt));

   // prints counts and verdict, then ends the run
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // cuts a hang short
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         report_and_stop;
      end
   end

   // value comparison
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   // one write strobe, outputs sampled once settled
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge mclk_i);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk_i);
      req <= '0;
      #1;
   endtask

   // one read strobe, answer taken in the cycle after
   task automatic rd(logic [3:0] a, output logic v, output logic [7:0] d);
      @(posedge mclk_i);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk_i);
      req <= '0;
      #1;
      v = rsp.valid;
      d = rsp.rdata;
   endtask

   // read that must be answered with an expected byte
   task automatic rdc(string n, logic [3:0] a, logic [7:0] e);
      logic       v;
      logic [7:0] d;
      rd(a, v, d);
      chk("valid", 16'h0001, 16'(v));
      chk(n, 16'(e), 16'(d));
   endtask

   initial begin
      logic       v;
      logic [7:0] d;
      logic [3:0] p0;
      repeat (10) @(posedge mclk_i);
      resetn_i <= 1'b1;
      #1;
      chk("mask", 16'h000f, 16'(mask));
      chk("cmd", 16'h0000, 16'(cmd));
      // word registers through the byte pointer
      wr(OFS_PTR_CLEAR, 8'hff);
      wr(OFS_CH2_COUNT, 8'h34);
      wr(OFS_CH2_COUNT, 8'h12);
      chk("c2", 16'h1234, c2);
      wr(OFS_CHAN3_CURRENT_ADDRESS, 8'h78);
      wr(OFS_PTR_CLEAR, 8'h00);
      wr(OFS_CHAN3_CURRENT_ADDRESS, 8'h9a);
      wr(OFS_CHAN3_CURRENT_ADDRESS, 8'hbc);
      chk("a3", 16'hbc9a, a3);
      wr(OFS_CH2_ADDR, 8'h01);
      wr(OFS_CH2_ADDR, 8'hfe);
      chk("a2", 16'hfe01, a2);
      wr(OFS_CH3_COUNT, 8'hff);
      wr(OFS_CH3_COUNT, 8'h80);
      chk("c3", 16'h80ff, c3);
      wr(OFS_PTR_CLEAR, 8'h00);
      rdc("c2 low", OFS_CH2_COUNT, 8'h34);
      rdc("c2 high", OFS_CH2_COUNT, 8'h12);
      rdc("a3 low", OFS_CHAN3_CURRENT_ADDRESS, 8'h9a);
      // command byte, and a write while the bus is owned
      foreach (cv[i]) begin
         wr(OFS_STAT_CMD, cv[i]);
         chk("cmd", 16'(cv[i]), 16'(cmd));
      end
      @(posedge mclk_i);
      hold <= 1'b1;
      wr(OFS_STAT_CMD, 8'hff);
      chk("cmd held", 16'h0000, 16'(cmd));
      @(posedge mclk_i);
      hold <= 1'b0;
      // software requests and single masks per channel
      for (int i = 0; i < 4; i++) begin
         wr(OFS_SW_REQ, 8'h04 | 8'(i));
         chk("sreq", 16'((1 << (i + 1)) - 1), 16'(sreq));
      end
      for (int i = 0; i < 4; i++) begin
         wr(OFS_SW_REQ, 8'(i));
         chk("sreq", 16'((32'hf << (i + 1)) & 32'hf), 16'(sreq));
         wr(OFS_SNGL_MASK, 8'(i));
         chk("mask", 16'((32'hf << (i + 1)) & 32'hf), 16'(mask));
      end
      wr(OFS_SNGL_MASK, 8'h06);
      chk("mask", 16'h0004, 16'(mask));
      // status flags, read clear and mirror
      rd(OFS_STAT_CMD, v, d);
      @(posedge mclk_i);
      rq_ev <= 4'h4;
      tc_ev <= 4'h8;
      @(posedge mclk_i);
      rq_ev <= 4'h0;
      tc_ev <= 4'h0;
      repeat (3) @(posedge mclk_i);
      #1;
      chk("mirror", 16'h0048, 16'(bstat));
      rdc("status", OFS_STAT_CMD, 8'h48);
      @(posedge mclk_i);
      #1;
      chk("mirror", 16'h0000, 16'(bstat));
      rdc("status", OFS_STAT_CMD, 8'h00);
      // modes per channel, type validity
      foreach (mb[i]) begin
         wr(OFS_MODE, mb[i]);
         chk("mode", 16'(mb[i]), 16'(mode[i]));
      end
      chk("tvld", 16'h0003, 16'(tvld));
      wr(OFS_STAT_CMD, 8'h01);
      chk("tvld", 16'h0000, 16'(tvld));
      wr(OFS_STAT_CMD, 8'h00);
      chk("tvld", 16'h0003, 16'(tvld));
      rdc("unmapped", 4'h0, 8'h00);
      // read buffer fills while the drain stalls
      @(posedge mclk_i);
      stall <= 1'b1;
      wr(OFS_PTR_CLEAR, 8'h00);
      p0 = pcnt;
      rdc("buf 0", OFS_CH2_COUNT, 8'h34);
      rdc("buf 1", OFS_CH2_COUNT, 8'h12);
      rd(OFS_STAT_CMD, v, d);
      chk("refused", 16'h0000, 16'(v));
      chk("head", 16'h0034, 16'(bdat));
      chk("bvld", 16'h0001, 16'(bvld));
      @(posedge mclk_i);
      stall <= 1'b0;
      repeat (3) @(posedge mclk_i);
      #1;
      chk("pops", 16'(p0 + 4'h2), 16'(pcnt));
      chk("last pop", 16'h0012, 16'(pdat));
      chk("bvld", 16'h0000, 16'(bvld));
      report_and_stop;
   end
endmodule
`default_nettype wire
